// [core/srs_pkg.sv]
// Shared constants, states and carriers of the reset sequencer.
package srs_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;                 // Sys clock period.
    localparam int TCL_NS        = CLK_PERIOD_NS / 2;  // Half clock period.
    localparam int FILT_MIN_NS   = 50;                 // Shortest kept pulse.
    // Least time, so it rounds up.
    localparam int FILT_CYC =
        (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DET_TCL  = 4;     // Least valid low before the wait.
    localparam int DET_CYC  =
        (DET_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_TCL = 12;    // Longest wait, so it rounds down.
    localparam int WAIT_CYC = WAIT_TCL * TCL_NS / CLK_PERIOD_NS;
    localparam int SEQ_TCL  = 1024;  // Internal sequence length.
    localparam int SEQ_CYC  = SEQ_TCL * TCL_NS / CLK_PERIOD_NS;
    localparam int SMP_TCL  = 8;     // Delay before the classification.
    localparam int SMP_CYC  = SMP_TCL * TCL_NS / CLK_PERIOD_NS;
    localparam int TEND_TCL = 3;     // Least delay to end transparency.
    localparam int TEND_CYC =
        (TEND_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [15:0] CFG_LATCH_OFS = 16'hF108;
    localparam logic [15:0] CTRL_OFS      = 16'hF10C;
    localparam logic [15:0] STAT_OFS      = 16'hF110;
    localparam logic [15:0] MASK_OFS      = 16'hF114;
    localparam int          CTRL_BIDIR    = 0;   // Bidirectional enable.
    localparam int          EVT_SHORT     = 0;   // Short reset done.
    localparam int          EVT_LONG      = 1;   // Long reset done.
    localparam int          EVT_FLASH     = 2;   // Flash-only reset.
    localparam int          EVT_W         = 3;
    localparam int          CFG_LSB       = 8;   // Latch takes high byte.
    localparam int          CLKCFG_LSB    = 13;  // Clock option pins.
    localparam logic [7:0]  CFG_LATCH_RST = 8'h00;
    localparam logic [2:0]  CLKCFG_RST    = 3'h7;
    localparam logic [2:0]  MASK_RST      = 3'h0;
    localparam logic        BIDIR_RST     = 1'b0;
    localparam logic [15:0] FLASH_BLANK   = 16'hFFFF;
    localparam logic [23:0] FETCH_START   = 24'h00_0000;

    // One-hot sequencer states.
    typedef enum logic [6:0] {
        S_RUN    = 7'h01,
        S_DETECT = 7'h02,
        S_WAIT   = 7'h04,
        S_SEQ    = 7'h08,
        S_SAMPLE = 7'h10,
        S_LONG   = 7'h20,
        S_EXIT   = 7'h40
    } srs_state_t;

    // Register port request.
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } srs_bus_req_t;

    // Flash read answer.
    typedef struct packed {
        logic [15:0] data;
        logic        valid;
    } srs_flash_t;

endpackage

// [core/srs_filter.sv]
// Synchroniser and digital spike filter for the reset input pin.
`timescale 1ns/100ps
module srs_filter #(
    parameter int FILT = srs_pkg::FILT_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pinRaw,
    output logic      filtLow
);
    import srs_pkg::*;

    // All state of the filter.
    typedef struct packed {
        logic       sync1;  // First synchroniser stage.
        logic       sync2;  // Second synchroniser stage.
        logic [3:0] cnt;    // Consecutive low samples.
        logic       low;    // Filtered line, high means reset asked.
    } srs_filt_t;

    srs_filt_t st_reg;
    srs_filt_t st_next;

    // ****************************************************************
    // Filter
    // ****************************************************************
    // Lows shorter than FILT cycles never reach the line; a high
    // releases it at once.
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pinRaw;
        st_next.sync2 = st_reg.sync1;
        if (st_reg.sync2) begin
            st_next.cnt = 4'h0;
            st_next.low = 1'b0;
        end else if (st_reg.cnt == 4'(FILT - 1)) begin
            st_next.low = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end
    end

    // Registers the filter state; the pin idles high.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= '{sync1: 1'b1, sync2: 1'b1, cnt: 4'h0, low: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign filtLow = st_reg.low;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    spike_reject_a: assert property (
        $rose(filtLow) |-> $past(!st_reg.sync2) && $past(!st_reg.sync2, 2))
        else $error("Filtered line fell on a short spike.");
endmodule

// [core/srs_core.sv]
// Synchronous hardware reset sequencer with register port.
// What this block does
// - Reject reset input pulses under 50 ns.
// - Start internal sequence within 16 half-clocks.
// - Internal sequence lasts exactly 1024 half-clocks.
// - Sample line 8 later: short or long.
// - Long reset opens the clock option pins.
// - Bidirectional mode drives pin during sequence.
// - Slow clock makes bidirectional pulses short.
// - Close clock pins 3-4 half-clocks after release.
// - Unidirectional release at end classifies alike.
// - Too short pulse resets only flash.
// - Flash-only reset reads ones and traps.
// - Extend while low, and during flash init when extAccessSel is set.
// - Exit latches config, bus strobes inactive.
// - Restart fetch at address zero.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module srs_core
    import srs_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  resetPinIn,
    output logic                       resetPinOut,
    output logic                       resetPinOe,
    input  wire logic                  extAccessSel,
    input  wire logic                  flashInitDone,
    input  wire logic [15:0]           port0In,
    output logic [2:0]                 clockCfgPins,
    output logic                       cfgTransparent,
    input  wire srs_pkg::srs_bus_req_t busReq,
    output logic [15:0]                busRdData,
    input  wire srs_pkg::srs_flash_t   flashIn,
    output logic [15:0]                cpuRdData,
    output logic                       illegalTrap,
    output logic                       sysResetOut,
    output logic                       flashResetOut,
    output logic                       busIdleForce,
    output logic                       fetchStart,
    output logic [23:0]                fetchAddr,
    output logic                       irq
);
    import srs_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    // All state of the sequencer in one record.
    typedef struct packed {
        srs_state_t       state;     // Sequencer state.
        logic [9:0]       cnt;       // Cycle counter of the state.
        logic             flashOnly; // Flash held in its blank mode.
        logic             sysRst;    // Internal system reset.
        logic             pinOe;     // Driving the reset pin low.
        logic             transp;    // Clock option pins open.
        logic             busIdle;   // Bus strobes forced inactive.
        logic             fetch;     // Fetch restart pulse.
        logic             trap;      // Illegal opcode trap pulse.
        logic [15:0]      rdData;    // Data to the CPU fetch path.
        logic [2:0]       clkCfg;    // Clock option pins, held.
        logic [7:0]       cfgLatch;  // Start-up configuration.
        logic             bidirEn;   // Bidirectional reset enable.
        logic [EVT_W-1:0] status;    // Sticky events.
        logic [EVT_W-1:0] mask;      // Interrupt mask.
        logic [15:0]      busRd;     // Register read answer.
    } srs_core_t;

    srs_core_t        st_reg;   // Registered state.
    srs_core_t        st_next;  // Next state.
    logic             filtLow;  // Filtered line, high while asked.
    logic [EVT_W-1:0] evt;      // Events of this cycle.
    logic [EVT_W-1:0] clr;      // Write-one-to-clear bits.

    // ****************************************************************
    // Input filter
    // ****************************************************************
    // Synchronised and filtered in the sys_clk domain.
    srs_filter #(
        .FILT    (FILT_CYC)
    ) u_filter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pinRaw  (resetPinIn),
        .filtLow (filtLow)
    );

    // ****************************************************************
    // Sequencer and registers
    // ****************************************************************
    // Each half-clock count is halved into sys_clk cycles.
    always_comb begin
        st_next       = st_reg;
        st_next.fetch = 1'b0;
        st_next.trap  = 1'b0;
        st_next.busRd = 16'h0000;
        evt           = '0;
        clr           = '0;
        unique case (st_reg.state)
            S_RUN: begin
                // A filtered low starts the validity check.
                if (filtLow) begin
                    st_next.state = S_DETECT;
                    st_next.cnt   = 10'h000;
                end
            end
            S_DETECT: begin
                if (!filtLow) begin
                    // Passed the filter but too short: flash only.
                    st_next.flashOnly = 1'b1;
                    evt[EVT_FLASH]    = 1'b1;
                    st_next.state     = S_RUN;
                end else if (st_reg.cnt == 10'(DET_CYC - 1)) begin
                    st_next.state = S_WAIT;
                    st_next.cnt   = 10'h000;
                end else begin
                    st_next.cnt = st_reg.cnt + 10'h001;
                end
            end
            S_WAIT: begin
                // The sequence starts no later than the bound.
                if (st_reg.cnt == 10'(WAIT_CYC - 1)) begin
                    st_next.state     = S_SEQ;
                    st_next.cnt       = 10'h000;
                    st_next.sysRst    = 1'b1;
                    st_next.busIdle   = 1'b1;
                    st_next.flashOnly = 1'b0;
                    st_next.pinOe     = st_reg.bidirEn;
                end else begin
                    st_next.cnt = st_reg.cnt + 10'h001;
                end
            end
            S_SEQ: begin
                // Fixed length; the pin is released at its end.
                if (st_reg.cnt == 10'(SEQ_CYC - 1)) begin
                    st_next.state = S_SAMPLE;
                    st_next.cnt   = 10'h000;
                    st_next.pinOe = 1'b0;
                end else begin
                    st_next.cnt = st_reg.cnt + 10'h001;
                end
            end
            S_SAMPLE: begin
                // The released pin may still look low through the
                // analogue delay, so the class can go either way.
                if (st_reg.cnt == 10'(SMP_CYC - 1)) begin
                    st_next.cnt    = 10'h000;
                    evt[EVT_SHORT] = 1'b1;
                    if (filtLow) begin
                        evt[EVT_LONG]  = 1'b1;
                        st_next.state  = S_LONG;
                        st_next.transp = 1'b1;
                    end else begin
                        st_next.state = S_EXIT;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + 10'h001;
                end
            end
            S_LONG: begin
                // Pins stay open while low, then close after a delay.
                if (filtLow) begin
                    st_next.cnt = 10'h000;
                end else if (st_reg.cnt == 10'(TEND_CYC - 1)) begin
                    st_next.transp = 1'b0;
                    st_next.state  = S_EXIT;
                end else begin
                    st_next.cnt = st_reg.cnt + 10'h001;
                end
            end
            S_EXIT: begin
                // Held while low, or while the flash initialises with extAccessSel set.
                if (!filtLow &&
                    !(extAccessSel && !flashInitDone)) begin
                    st_next.state    = S_RUN;
                    st_next.sysRst   = 1'b0;
                    st_next.fetch    = 1'b1;
                    st_next.cfgLatch =
                        port0In[CFG_LSB +: 8];
                end
            end
            default: begin
                // An illegal code falls back to normal running.
                st_next.state = S_RUN;
            end
        endcase

        // Strobes stay inactive through the restart cycle.
        st_next.busIdle = st_next.sysRst | st_reg.sysRst;

        // Open clock option pins follow the port.
        if (st_reg.transp) begin
            st_next.clkCfg = port0In[CLKCFG_LSB +: 3];
        end

        // Flash reads give all ones and trap in flash-only mode.
        if (flashIn.valid) begin
            st_next.rdData =
                st_reg.flashOnly ? FLASH_BLANK : flashIn.data;
            st_next.trap = st_reg.flashOnly;
        end

        // Register writes.
        if (busReq.wr) begin
            unique case (busReq.addr)
                CTRL_OFS: st_next.bidirEn = busReq.wdata[CTRL_BIDIR];
                STAT_OFS: clr = busReq.wdata[EVT_W-1:0];
                MASK_OFS: st_next.mask = busReq.wdata[EVT_W-1:0];
                default: begin
                    // Unmapped or read-only: the write is dropped.
                end
            endcase
        end
        // A new event wins over its clear.
        st_next.status = (st_reg.status & ~clr) | evt;

        // Register reads answer in the next cycle; unmapped is zero.
        if (busReq.rd) begin
            unique case (busReq.addr)
                CFG_LATCH_OFS: st_next.busRd = {8'h00, st_reg.cfgLatch};
                CTRL_OFS:      st_next.busRd = {15'h0000, st_reg.bidirEn};
                STAT_OFS:      st_next.busRd = {13'h0000, st_reg.status};
                MASK_OFS:      st_next.busRd = {13'h0000, st_reg.mask};
                default:       st_next.busRd = 16'h0000;
            endcase
        end
    end

    // Registers the whole state.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= '{state: S_RUN, cnt: 10'h000, flashOnly: 1'b0,
                        sysRst: 1'b0, pinOe: 1'b0, transp: 1'b0,
                        busIdle: 1'b0, fetch: 1'b0, trap: 1'b0,
                        rdData: 16'h0000, clkCfg: CLKCFG_RST,
                        cfgLatch: CFG_LATCH_RST, bidirEn: BIDIR_RST,
                        status: 3'h0, mask: MASK_RST,
                        busRd: 16'h0000};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output except the constants resetPinOut and fetchAddr is read from the registered record.
    assign resetPinOut    = 1'b0;  // Open drain, only pulls low.
    assign resetPinOe     = st_reg.pinOe;
    assign clockCfgPins   = st_reg.clkCfg;
    assign cfgTransparent = st_reg.transp;
    assign busRdData      = st_reg.busRd;
    assign cpuRdData      = st_reg.rdData;
    assign illegalTrap    = st_reg.trap;
    assign sysResetOut    = st_reg.sysRst;
    assign flashResetOut  = st_reg.sysRst | st_reg.flashOnly;
    assign busIdleForce   = st_reg.busIdle;
    assign fetchStart     = st_reg.fetch;
    assign fetchAddr      = FETCH_START;
    // Level interrupt while an unmasked event is pending.
    assign irq            = |(st_reg.status & st_reg.mask);

    // ****************************************************************
    // Checks
    // ****************************************************************
    localparam int START_MAX = 8;  // Detect to sequence, in cycles.

    logic       inSeq;   // Sequence state flag.
    logic [9:0] seqLen;  // Cycles spent in the sequence.
    assign inSeq = (st_reg.state == S_SEQ);

    // Counts the sequence length for the checks.
    always_ff @(posedge sys_clk) begin
        if (rst || !inSeq) begin
            seqLen <= 10'h000;
        end else begin
            seqLen <= seqLen + 10'h001;
        end
    end

    // All checks run on sys_clk and pause during reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    seq_start_a: assert property (
        $rose(st_reg.state == S_DETECT) |->
            ##[1:START_MAX] (inSeq || st_reg.state == S_RUN))
        else $error("Sequence did not start in time.");
    seq_length_a: assert property (
        $fell(inSeq) |-> $past(seqLen) == 10'(SEQ_CYC - 1))
        else $error("Sequence length is wrong.");
    classify_long_a: assert property (
        (st_reg.state == S_SAMPLE && st_reg.cnt == 10'(SMP_CYC - 1)) |=>
            ((st_reg.state == S_LONG) == $past(filtLow)) &&
            st_reg.status[EVT_SHORT])
        else $error("Short or long class is wrong.");
    long_open_a: assert property (
        (st_reg.state == S_LONG) |-> cfgTransparent)
        else $error("Clock pins closed during a long reset.");
    pin_drive_a: assert property (
        $rose(inSeq) |-> resetPinOe == $past(st_reg.bidirEn))
        else $error("Reset pin drive does not follow the mode.");
    pin_release_a: assert property (
        $fell(inSeq) |-> !resetPinOe)
        else $error("Reset pin not released at sequence end.");
    close_delay_a: assert property (
        (st_reg.state == S_LONG && $rose(filtLow == 1'b0)) |->
            cfgTransparent ##2 !cfgTransparent)
        else $error("Clock pins did not close on time.");
    flash_only_a: assert property (
        $rose(st_reg.flashOnly) |-> !sysResetOut && flashResetOut)
        else $error("Flash-only reset reset the system.");
    flash_blank_a: assert property (
        (flashIn.valid && st_reg.flashOnly) |=>
            cpuRdData == FLASH_BLANK && illegalTrap)
        else $error("Flash-only read did not trap on ones.");
    exit_hold_a: assert property (
        (st_reg.state == S_EXIT &&
         (filtLow || (extAccessSel && !flashInitDone))) |=>
            st_reg.state == S_EXIT)
        else $error("Reset left too early.");
    restart_a: assert property (
        $rose(fetchStart) |-> busIdleForce && fetchAddr == FETCH_START)
        else $error("Restart without idle strobes or at bad address.");

    // Clock option pins track the port while open.
    pins_follow_a: assert property (
        cfgTransparent |=> clockCfgPins == $past(port0In[CLKCFG_LSB +: 3]))
        else $error("Clock pins did not follow the port.");

    // A full sequence ends the flash-only mode.
    flash_end_a: assert property (
        $rose(inSeq) |-> !st_reg.flashOnly)
        else $error("Flash-only mode outlived the sequence start.");

    // Covers for the main scenarios.
    short_seen_c: cover property ($rose(st_reg.status[EVT_SHORT]));
    long_seen_c:  cover property ($rose(st_reg.transp));
    flash_seen_c: cover property ($rose(st_reg.flashOnly));
    irq_seen_c:   cover property ($rose(irq));
endmodule

// [verification/srs_reset_source.sv]
// Model of the external source that pulls the reset pin low.
`timescale 1ns/100ps
module srs_reset_source (
    input  wire logic        sys_clk,
    input  wire logic        start,
    input  wire logic [15:0] lowCycles,
    output logic             pinLow
);
    logic [15:0] cntReg = 16'h0000;  // Low cycles still to drive.

    // A request loads the length, then the pin is held low that long.
    always_ff @(posedge sys_clk) begin
        if (start) begin
            cntReg <= lowCycles;
        end else if (cntReg != 16'h0000) begin
            cntReg <= cntReg - 16'h0001;
        end
    end
    // The line is only pulled while counting, else the pull-up wins.
    assign pinLow = (cntReg != 16'h0000);
endmodule

// [verification/sync_reset_sequencer_tb_top.sv]
// Self-checking testbench of the reset sequencer core.
`timescale 1ns/100ps
module sync_reset_sequencer_tb_top
    import srs_pkg::*;
;
    logic         sys_clk = 1'b0;   // System clock.
    logic         rst, start;       // Reset and source request.
    logic [15:0]  lowLen, port0In;  // Pulse length and port 0.
    logic         extAccessSel, flashInitDone, srcLow;
    srs_bus_req_t busReq;           // Register port request.
    srs_flash_t   flashIn;          // Flash read answer.
    logic         resetPinOe, cfgTransparent, sysResetOut, fetchStart;
    logic         illegalTrap, flashResetOut, busIdleForce, irq;
    logic [2:0]   clockCfgPins;
    logic [15:0]  busRdData, cpuRdData;
    logic [23:0]  fetchAddr;
    wire          pinLevel;         // Open-drain pin with pull-up.
    int           n_errors = 0, n_checks = 0, cycles = 0;

    assign pinLevel = !(srcLow || resetPinOe);
    always #20 sys_clk = ~sys_clk;

    srs_core dut (.sys_clk(sys_clk), .rst(rst), .resetPinIn(pinLevel),
        .resetPinOut(), .resetPinOe(resetPinOe),
        .extAccessSel(extAccessSel), .flashInitDone(flashInitDone),
        .port0In(port0In), .clockCfgPins(clockCfgPins),
        .cfgTransparent(cfgTransparent), .busReq(busReq),
        .busRdData(busRdData), .flashIn(flashIn), .cpuRdData(cpuRdData),
        .illegalTrap(illegalTrap), .sysResetOut(sysResetOut),
        .flashResetOut(flashResetOut), .busIdleForce(busIdleForce),
        .fetchStart(fetchStart), .fetchAddr(fetchAddr), .irq(irq));
    srs_reset_source src (.sys_clk(sys_clk), .start(start),
        .lowCycles(lowLen), .pinLow(srcLow));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Compares one value and reports a mismatch.
    task automatic check(input string nm, input logic [23:0] exp,
                         input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        busReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1 d = busRdData;
    endtask
    // Asks the source for a low pulse of n cycles.
    task automatic pull(input logic [15:0] n);
        @(posedge sys_clk);
        lowLen <= n;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
    endtask
    // Counts cycles until the sequence starts, bounded.
    task automatic wait_seq(output int n);
        n = 0;
        while (sysResetOut !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        logic [15:0] d;
        logic [15:0] adr [5] = '{CFG_LATCH_OFS, CTRL_OFS, STAT_OFS,
                                 MASK_OFS, 16'hF200};
        wr(CFG_LATCH_OFS, 16'h00FF);
        foreach (adr[i]) begin
            rd(adr[i], d);
            check("reset value", 24'h0, 24'(d));
        end
        check("clock pins", 24'(CLKCFG_RST), 24'(clockCfgPins));
        $display("register reset values done.");
    endtask

    task automatic t_spike();
        logic [15:0] d;
        pull(16'h0001);
        tick(12);
        rd(STAT_OFS, d);
        check("spike status", 24'h0, 24'(d));
        check("spike reset", 24'h0, 24'(sysResetOut));
        $display("spike filter done.");
    endtask

    task automatic t_flash();
        logic [15:0] d;
        pull(16'h0002);
        tick(12);
        rd(STAT_OFS, d);
        check("flash status", 24'h4, 24'(d));
        check("flash reset", 24'h1, 24'(flashResetOut));
        check("sys reset", 24'h0, 24'(sysResetOut));
        @(posedge sys_clk);
        flashIn <= '{16'h1234, 1'b1};
        @(posedge sys_clk);
        flashIn.valid <= 1'b0;
        #1 check("flash data", 24'(FLASH_BLANK), 24'(cpuRdData));
        check("trap", 24'h1, 24'(illegalTrap));
        wr(STAT_OFS, 16'h0004);
        $display("flash-only reset done.");
    endtask

    task automatic t_short(input logic bidir);
        logic [15:0] d;
        int n, k;
        wr(CTRL_OFS, {15'h0000, bidir});
        wr(MASK_OFS, 16'h0001);
        port0In <= 16'hE35A;
        pull(16'd20);
        wait_seq(n);
        check("start delay", 24'h1,
              24'(n <= 4 + DET_CYC + WAIT_CYC + 2));
        n = 0;
        k = 0;
        while (sysResetOut === 1'b1 && n < 3000) begin
            k += int'(resetPinOe);
            tick(1);
            n++;
        end
        check("pin drive", bidir ? 24'(SEQ_CYC) : 24'h0, 24'(k));
        if (!bidir) begin
            check("seq len", 24'(SEQ_CYC + SMP_CYC + 1), 24'(n));
        end
        check("fetch", 24'h1, 24'(fetchStart));
        check("fetch addr", FETCH_START, fetchAddr);
        tick(1);
        check("bus idle", 24'h0, 24'(busIdleForce));
        rd(CFG_LATCH_OFS, d);
        check("cfg latch", 24'h00E3, 24'(d));
        rd(STAT_OFS, d);
        check("short flag", 24'h1, 24'(d));
        check("irq set", 24'h1, 24'(irq));
        wr(MASK_OFS, 16'h0000);
        #1 check("irq masked", 24'h0, 24'(irq));
        wr(STAT_OFS, 16'h0007);
        rd(STAT_OFS, d);
        check("status cleared", 24'h0, 24'(d));
        $display("short reset done.");
    endtask

    task automatic t_long();
        logic [15:0] d;
        int n;
        wr(CTRL_OFS, 16'h0000);
        extAccessSel <= 1'b1;
        flashInitDone <= 1'b0;
        port0In <= 16'hA000;
        pull(16'd600);
        wait_seq(n);
        tick(530);
        check("transparent", 24'h1, 24'(cfgTransparent));
        port0In <= 16'h4000;
        tick(2);
        check("clock pins", 24'h2, 24'(clockCfgPins));
        n = 0;
        while (srcLow === 1'b1 && n < 700) begin
            tick(1);
            n++;
        end
        n = 0;
        while (cfgTransparent === 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check("close delay", 24'h1, 24'(n >= 3 + TEND_CYC
                                        && n <= 5 + TEND_CYC));
        tick(10);
        check("flash init hold", 24'h1, 24'(sysResetOut));
        flashInitDone <= 1'b1;
        n = 0;
        while (fetchStart !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        check("restart", 24'h1, 24'(fetchStart));
        rd(STAT_OFS, d);
        check("long flags", 24'h3, 24'(d));
        check("pins kept", 24'h2, 24'(clockCfgPins));
        @(posedge sys_clk);
        flashIn <= '{16'h1234, 1'b1};
        @(posedge sys_clk);
        flashIn.valid <= 1'b0;
        #1 check("flash pass", 24'h1234, 24'(cpuRdData));
        $display("long reset done.");
    endtask

    // Cuts a hang short.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    // Main sequence.
    initial begin
        {rst, start, lowLen, extAccessSel, port0In} = {2'b10, 33'h0};
        flashInitDone = 1'b1;
        busReq = '0;
        flashIn = '0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_spike();
        t_flash();
        t_short(1'b0);
        t_short(1'b1);
        t_long();
        print_verdict();
    end
endmodule
